// ### src/etc_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the elapsed time counter
// Assumes: 10 MHz reference clock, APB byte addresses on 8 bits
// Notes: included by bare name from the design files
`ifndef ETC_CFG_SVH
`define ETC_CFG_SVH

// register byte offsets
`define ETC_OFF_CTRL 8'h00
`define ETC_OFF_LIMIT 8'h04
`define ETC_OFF_CMD 8'h08
`define ETC_OFF_LIVE 8'h0C
`define ETC_OFF_CAPT 8'h10
`define ETC_OFF_STATUS 8'h14
`define ETC_OFF_MASK 8'h18
`define ETC_OFF_STATE 8'h1C

// control field positions
`define ETC_CTRL_ACTIVE 0
`define ETC_CTRL_TICKSRC 1
`define ETC_CTRL_BEGIN_LSB 4
`define ETC_CTRL_BEGIN_MSB 5
`define ETC_CTRL_CLEAR_LSB 8
`define ETC_CTRL_CLEAR_MSB 9
`define ETC_CMD_CLEAR 0

// status and mask bit positions
`define ETC_ST_LIMIT 0
`define ETC_ST_END 1
`define ETC_ST_BEGIN 2

// reset values
`define ETC_CTRL_RST 32'h0000_0000
`define ETC_LIMIT_RST 32'hFFFF_FFFF
`define ETC_MASK_RST 3'h0

// timing: the microsecond tick derived from the reference clock
`define ETC_CLK_NS 100
`define ETC_TICK_NS 1000
`define ETC_TICK_CYCLES (`ETC_TICK_NS / `ETC_CLK_NS)

`endif

// ### src/etc_counter.sv
// Purpose: elapsed time counter between two selectable camera events, APB slave
// Assumes: one 10 MHz clock, synchronous active-low reset, event inputs synchronous
// Notes: APB answers with one wait state; all outputs are registered
//
// Register access over APB and the address map were left to the implementer.
`include "etc_cfg.svh"

module etc_counter
   import etc_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter int TICK_DIV = `ETC_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic exposureBeginEvent,
   input wire logic exposureFinishEvent,
   input wire logic externalIncrement,
   output logic countLimitEvent,
   output logic irq
);
   logic [31:0] ctrl;
   logic [CNT_W-1:0] countLimit;
   logic [CNT_W-1:0] liveCount;
   logic [CNT_W-1:0] capturedCount;
   logic [2:0] status;
   logic [2:0] mask;
   etc_state_e state;
   logic extPrev;

   logic [31:0] next_ctrl;
   logic [CNT_W-1:0] next_countLimit;
   logic [CNT_W-1:0] next_liveCount;
   logic [CNT_W-1:0] next_capturedCount;
   logic [2:0] next_status;
   logic [2:0] next_mask;
   etc_state_e next_state;
   logic next_pready;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic next_countLimitEvent;
   logic next_irq;

   logic active;
   logic tickSourceSelect;
   etc_src_e beginSel;
   etc_src_e clearSel;
   logic tickUs;
   logic tick;
   logic beginHit;
   logic clearHit;
   logic accessCycle;
   logic commit;
   logic wrCommit;
   logic mapped;
   logic swClear;
   logic limitHit;
   logic periodEnd;
   logic periodBegin;
   logic [CNT_W-1:0] incCount;
   logic [31:0] readValue;

   // decoded control fields
   assign active = ctrl[`ETC_CTRL_ACTIVE];
   assign tickSourceSelect = ctrl[`ETC_CTRL_TICKSRC];
   assign beginSel = etc_src_e'(ctrl[`ETC_CTRL_BEGIN_MSB:`ETC_CTRL_BEGIN_LSB]);
   assign clearSel = etc_src_e'(ctrl[`ETC_CTRL_CLEAR_MSB:`ETC_CTRL_CLEAR_LSB]);

   // tick only runs while the counter is active, so the first tick is a full microsecond away
   etc_tick_gen #(
      .DIV(TICK_DIV)
   ) u_tick (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .enable(active),
      .tick(tickUs)
   );

   etc_event_pick u_pick (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .eventLevel({exposureFinishEvent, exposureBeginEvent}),
      .beginSel(beginSel),
      .clearSel(clearSel),
      .beginHit(beginHit),
      .clearHit(clearHit)
   );

   // increment source: internal tick or a rising edge of the external line
   assign tick = tickSourceSelect ? (externalIncrement & ~extPrev) : tickUs;
   assign incCount = liveCount + CNT_W'(1);

   // apb phases: the answer comes one cycle into the access phase
   assign accessCycle = psel & penable & ~pready;
   assign commit = psel & penable & pready;
   assign wrCommit = commit & pwrite;
   assign mapped = (paddr == `ETC_OFF_CTRL) || (paddr == `ETC_OFF_LIMIT) || (paddr == `ETC_OFF_CMD)
      || (paddr == `ETC_OFF_LIVE) || (paddr == `ETC_OFF_CAPT) || (paddr == `ETC_OFF_STATUS)
      || (paddr == `ETC_OFF_MASK) || (paddr == `ETC_OFF_STATE);
   assign swClear = wrCommit & (paddr == `ETC_OFF_CMD) & pwdata[`ETC_CMD_CLEAR];

   // read mux, unmapped addresses read zero
   always_comb begin
      readValue = 32'h0000_0000;
      case (paddr)
         `ETC_OFF_CTRL: readValue = ctrl;
         `ETC_OFF_LIMIT: readValue = 32'(countLimit);
         `ETC_OFF_LIVE: readValue = 32'(liveCount);
         `ETC_OFF_CAPT: readValue = 32'(capturedCount);
         `ETC_OFF_STATUS: readValue = {29'h0000_0000, status};
         `ETC_OFF_MASK: readValue = {29'h0000_0000, mask};
         `ETC_OFF_STATE: readValue = {30'h0000_0000, state};
         default: readValue = 32'h0000_0000;
      endcase
   end

   // counting period next values; a software clear outranks every event
   always_comb begin
      next_state = state;
      next_liveCount = liveCount;
      next_capturedCount = capturedCount;
      limitHit = 1'b0;
      periodEnd = 1'b0;
      periodBegin = 1'b0;
      if (!active) begin
         next_state = ST_IDLE;
      end else if (swClear) begin
         next_capturedCount = liveCount;
         next_liveCount = '0;
         next_state = ST_COUNT;
         periodEnd = 1'b1;
      end else begin
         unique case (state)
            ST_IDLE: begin
               // limit as begin source means free running from activation
               if (beginSel == SRC_LIMIT) begin
                  next_liveCount = '0;
                  next_state = ST_COUNT;
                  periodBegin = 1'b1;
               end else if (beginSel == SRC_OFF) begin
                  next_state = ST_HALT;
               end else begin
                  next_state = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (beginHit) begin
                  next_liveCount = '0;
                  next_state = ST_COUNT;
                  periodBegin = 1'b1;
               end
            end
            ST_COUNT: begin
               if (clearHit) begin
                  next_capturedCount = liveCount;
                  next_liveCount = '0;
                  next_state = ST_HALT;
                  periodEnd = 1'b1;
               end else if (tick) begin
                  if (incCount == countLimit) begin
                     limitHit = 1'b1;
                     next_capturedCount = incCount;
                     next_liveCount = '0;
                     next_state = (beginSel == SRC_LIMIT) ? ST_COUNT : ST_HALT;
                     periodEnd = 1'b1;
                  end else begin
                     next_liveCount = incCount;
                  end
               end
            end
            ST_HALT: begin
               next_state = ST_HALT;
            end
         endcase
      end
   end

   // register file next values; a hardware set wins over a write-one clear
   always_comb begin
      next_ctrl = ctrl;
      next_countLimit = countLimit;
      next_mask = mask;
      next_status = status;
      if (wrCommit && paddr == `ETC_OFF_CTRL) begin
         next_ctrl = pwdata;
      end
      if (wrCommit && paddr == `ETC_OFF_LIMIT) begin
         next_countLimit = pwdata[CNT_W-1:0];
      end
      if (wrCommit && paddr == `ETC_OFF_MASK) begin
         next_mask = pwdata[2:0];
      end
      if (wrCommit && paddr == `ETC_OFF_STATUS) begin
         next_status = status & ~pwdata[2:0];
      end
      next_status[`ETC_ST_LIMIT] = next_status[`ETC_ST_LIMIT] | limitHit;
      next_status[`ETC_ST_END] = next_status[`ETC_ST_END] | periodEnd;
      next_status[`ETC_ST_BEGIN] = next_status[`ETC_ST_BEGIN] | periodBegin;
      next_irq = |(next_status & next_mask);
      next_countLimitEvent = limitHit;
      next_pready = accessCycle;
      next_prdata = (accessCycle && !pwrite) ? readValue : prdata;
      next_pslverr = accessCycle & ~mapped;
   end

   // all state and outputs registered here
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrl <= `ETC_CTRL_RST;
         countLimit <= CNT_W'(`ETC_LIMIT_RST);
         mask <= `ETC_MASK_RST;
         status <= 3'h0;
         state <= ST_IDLE;
         liveCount <= '0;
         capturedCount <= '0;
         extPrev <= 1'b0;
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         countLimitEvent <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         countLimit <= next_countLimit;
         mask <= next_mask;
         status <= next_status;
         state <= next_state;
         liveCount <= next_liveCount;
         capturedCount <= next_capturedCount;
         extPrev <= externalIncrement;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         countLimitEvent <= next_countLimitEvent;
         irq <= next_irq;
      end
   end

   // checks on the counting behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_inactive_holds: assert property (!active |=> $stable(liveCount) && state == ST_IDLE)
      else $error("count moved while inactive");
   a_tick_advance: assert property (active && !swClear && state == ST_COUNT && tick && !clearHit
      && incCount != countLimit |=> liveCount == $past(liveCount) + CNT_W'(1))
      else $error("count did not advance on tick");
   a_limit_ends: assert property (active && !swClear && state == ST_COUNT && !clearHit && tick
      && incCount == countLimit |=> countLimitEvent && liveCount == '0 && capturedCount == $past(incCount))
      else $error("limit did not end the period");
   a_begin_starts: assert property (active && !swClear && state == ST_WAIT && beginHit
      |=> state == ST_COUNT && liveCount == '0)
      else $error("begin event did not start counting");
   a_clear_ends: assert property (active && !swClear && state == ST_COUNT && clearHit
      |=> state == ST_HALT && liveCount == '0 && capturedCount == $past(liveCount))
      else $error("clear event did not end and capture");
   a_sw_restart: assert property (active && swClear
      |=> liveCount == '0 && state == ST_COUNT && capturedCount == $past(liveCount))
      else $error("software clear did not restart from zero");
   a_halt_stays: assert property (state == ST_HALT && active && !swClear
      |=> state == ST_HALT && liveCount == '0)
      else $error("counting resumed without software clear");
   a_limit_pulse: assert property (countLimitEvent |=> !countLimitEvent)
      else $error("limit event longer than one cycle");
   a_live_read: assert property (accessCycle && !pwrite && paddr == `ETC_OFF_LIVE
      |=> pready && prdata == 32'($past(liveCount)))
      else $error("live count readback wrong");
   a_us_spacing: assert property (active && !tickSourceSelect && tickUs |=> !tickUs [*2])
      else $error("microsecond ticks too close");
   a_wait_holds: assert property (active && !swClear && state == ST_WAIT && !beginHit
      |=> state == ST_WAIT && $stable(liveCount))
      else $error("counting started without begin event");
   a_begin_flag: assert property (active && !swClear && state == ST_WAIT && beginHit
      |=> status[`ETC_ST_BEGIN])
      else $error("period begin not flagged");
   a_end_flag: assert property (active && !swClear && state == ST_COUNT && clearHit
      |=> status[`ETC_ST_END])
      else $error("period end not flagged");

   c_begin_end: cover property (state == ST_COUNT ##[1:1000] state == ST_HALT);
   c_limit_hit: cover property (countLimitEvent);
   c_sw_clear: cover property (active && swClear && state == ST_HALT);
   c_irq_rise: cover property (!irq ##1 irq);
endmodule // etc_counter

// ### src/etc_event_pick.sv
// Purpose: rising-edge detection of camera events and begin/clear selection
// Assumes: event inputs are levels synchronous to ref_clk
// Notes: the limit choice is resolved by the counter itself, so it picks nothing here
module etc_event_pick
   import etc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] eventLevel,
   input etc_src_e beginSel,
   input etc_src_e clearSel,
   output logic beginHit,
   output logic clearHit
);
   logic [1:0] prevLevel;
   logic [1:0] rise;

   // one edge detector per event line
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_edge
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               prevLevel[i] <= 1'b0;
            end else begin
               prevLevel[i] <= eventLevel[i];
            end
         end
         assign rise[i] = eventLevel[i] & ~prevLevel[i];
      end
   endgenerate

   // map the selections onto the edges
   always_comb begin
      beginHit = (beginSel == SRC_EXP_BEGIN) ? rise[0] : (beginSel == SRC_EXP_FINISH) ? rise[1] : 1'b0;
      clearHit = (clearSel == SRC_EXP_BEGIN) ? rise[0] : (clearSel == SRC_EXP_FINISH) ? rise[1] : 1'b0;
   end
endmodule // etc_event_pick

// ### src/etc_pkg.sv
// Purpose: types shared by the elapsed time counter modules
// Assumes: nothing beyond plain SystemVerilog
// Notes: encodings of the source selects are the order of the enum
package etc_pkg;

   // event choices for both begin and clear selection
   typedef enum logic [1:0] {
      SRC_OFF,
      SRC_EXP_BEGIN,
      SRC_EXP_FINISH,
      SRC_LIMIT
   } etc_src_e;

   // counting period states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_COUNT,
      ST_HALT
   } etc_state_e;

endpackage : etc_pkg

// ### src/etc_tick_gen.sv
// Purpose: one-cycle microsecond tick from the reference clock
// Assumes: DIV reference cycles make one microsecond
// Notes: runs free while enabled, restarts its phase when disabled
module etc_tick_gen #(
   parameter int DIV = `ETC_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic enable,
   output logic tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] phase;
   logic [CW-1:0] next_phase;
   logic next_tick;

   // divider next values
   always_comb begin
      next_phase = phase;
      next_tick = 1'b0;
      if (!enable) begin
         next_phase = '0;
      end else if (phase == LAST) begin
         next_phase = '0;
         next_tick = 1'b1;
      end else begin
         next_phase = phase + CW'(1);
      end
   end

   // divider registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         phase <= '0;
         tick <= 1'b0;
      end else begin
         phase <= next_phase;
         tick <= next_tick;
      end
   end
endmodule // etc_tick_gen

// ### testbench/elapsed_time_event_counter_test.sv
// Purpose: self-checking bench of the elapsed time counter over APB
// Assumes: shortened tick divider, one wait state per APB transfer
// Notes: internal tick phase is not visible, so elapsed time is judged within one tick
`include "etc_cfg.svh"
module elapsed_time_event_counter_test;
   import etc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 4;
   logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic evBegin, evFinish, extInc, countLimitEvent, irq, lastB, lastF;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int fails, check_count, seed, n, k, lim, mLive, mCapt, hits0;
   int cyc = 0, limitHits = 0, tBegin = 0, tFinish = 0;

   etc_counter #(.CNT_W(32), .TICK_DIV(DIV)) etc_counter_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .exposureBeginEvent(evBegin), .exposureFinishEvent(evFinish),
      .externalIncrement(extInc), .countLimitEvent(countLimitEvent), .irq(irq));
   etc_camera_model etc_camera_model_inst (.ref_clk(ref_clk), .beginEvt(evBegin), .finishEvt(evFinish),
      .extInc(extInc));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // reference timeline: event rise cycles and limit pulses
   always @(posedge ref_clk) begin
      cyc++;
      if (countLimitEvent === 1'b1) limitHits++;
      if (evBegin === 1'b1 && lastB === 1'b0) tBegin = cyc;
      if (evFinish === 1'b1 && lastF === 1'b0) tFinish = cyc;
      lastB = evBegin;
      lastF = evFinish;
   end

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one APB transfer; waits for pready, takes data at that edge only
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t >= 50) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask

   function automatic logic [31:0] ctrlVal(input logic ext, input etc_src_e b, input etc_src_e c);
      return {22'h00_0000, c, 2'b00, b, 2'b00, ext, 1'b1};
   endfunction

   initial begin
      #3_000_000;
      fails++;
      conclude();
   end

   initial begin
      fails = 0;
      check_count = 0;
      seed = 32'h8264_c1cc;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      reset_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      // reset values, unmapped place, inactive counter ignores events
      rdchk("ctrl", `ETC_OFF_CTRL, `ETC_CTRL_RST);
      rdchk("limit", `ETC_OFF_LIMIT, `ETC_LIMIT_RST);
      rdchk("mask", `ETC_OFF_MASK, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped err", {31'h0, err}, 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      // random mask value reads back on its three bits, then cleared again
      n = $random(seed);
      apb(1'b1, `ETC_OFF_MASK, 32'(n));
      rdchk("mask rw", `ETC_OFF_MASK, 32'(n) & 32'h0000_0007);
      apb(1'b1, `ETC_OFF_MASK, 32'h0000_0000);
      etc_camera_model_inst.pulse(0);
      etc_camera_model_inst.pulses(3);
      // random levels on every event line must not move an inactive counter
      n = 4 + ($unsigned($random(seed)) % 8);
      repeat (n) etc_camera_model_inst.levels(3'($random(seed)));
      etc_camera_model_inst.levels(3'h0);
      rdchk("live idle", `ETC_OFF_LIVE, 32'h0000_0000);
      rdchk("state idle", `ETC_OFF_STATE, 32'h0000_0000);
      $display("test reset and inactive done");
      // elapsed time between exposure begin and finish
      apb(1'b1, `ETC_OFF_CTRL, ctrlVal(1'b0, SRC_EXP_BEGIN, SRC_EXP_FINISH));
      rdchk("state wait", `ETC_OFF_STATE, 32'h0000_0001);
      etc_camera_model_inst.pulse(0);
      rdchk("state count", `ETC_OFF_STATE, 32'h0000_0002);
      k = 3 + ($unsigned($random(seed)) % 5);
      repeat (k * DIV) @(posedge ref_clk);
      etc_camera_model_inst.pulse(1);
      mCapt = (tFinish - tBegin) / DIV;
      apb(1'b0, `ETC_OFF_CAPT, 32'h0000_0000);
      check("elapsed", {31'h0, (rd + 32'h1 >= 32'(mCapt)) && (rd <= 32'(mCapt + 1))}, 32'h1);
      rdchk("live cleared", `ETC_OFF_LIVE, 32'h0000_0000);
      rdchk("status", `ETC_OFF_STATUS, 32'h0000_0006);
      etc_camera_model_inst.pulse(0);
      repeat (3 * DIV) @(posedge ref_clk);
      rdchk("no restart", `ETC_OFF_LIVE, 32'h0000_0000);
      rdchk("state halt", `ETC_OFF_STATE, 32'h0000_0003);
      // interrupt raised by mask, cleared by write one
      apb(1'b1, `ETC_OFF_MASK, 32'h0000_0002);
      repeat (2) @(posedge ref_clk);
      check("irq set", {31'h0, irq}, 32'h0000_0001);
      apb(1'b1, `ETC_OFF_STATUS, 32'h0000_0002);
      repeat (2) @(posedge ref_clk);
      check("irq clear", {31'h0, irq}, 32'h0000_0000);
      rdchk("status w1c", `ETC_OFF_STATUS, 32'h0000_0004);
      $display("test elapsed and interrupt done");
      // software clear restarts at once, live follows each increment
      apb(1'b1, `ETC_OFF_CTRL, ctrlVal(1'b1, SRC_EXP_BEGIN, SRC_EXP_FINISH));
      apb(1'b1, `ETC_OFF_CMD, 32'h0000_0001);
      rdchk("state run", `ETC_OFF_STATE, 32'h0000_0002);
      mLive = 1 + ($unsigned($random(seed)) % 12);
      etc_camera_model_inst.pulses(mLive);
      rdchk("live", `ETC_OFF_LIVE, 32'(mLive));
      apb(1'b1, `ETC_OFF_CMD, 32'h0000_0001);
      rdchk("capt on clear", `ETC_OFF_CAPT, 32'(mLive));
      rdchk("live zero", `ETC_OFF_LIVE, 32'h0000_0000);
      $display("test software clear done");
      // limit ends the period with clear select off
      lim = 3 + ($unsigned($random(seed)) % 6);
      apb(1'b1, `ETC_OFF_CTRL, ctrlVal(1'b1, SRC_EXP_BEGIN, SRC_OFF));
      apb(1'b1, `ETC_OFF_LIMIT, 32'(lim));
      apb(1'b1, `ETC_OFF_CMD, 32'h0000_0001);
      apb(1'b1, `ETC_OFF_STATUS, 32'h0000_0007);
      hits0 = limitHits;
      etc_camera_model_inst.pulses(lim - 1);
      check("no early hit", 32'(limitHits - hits0), 32'h0000_0000);
      etc_camera_model_inst.pulse(2);
      // one more edge so the timeline has counted the pulse of the last edge
      @(posedge ref_clk);
      check("limit hit", 32'(limitHits - hits0), 32'h0000_0001);
      rdchk("capt limit", `ETC_OFF_CAPT, 32'(lim));
      etc_camera_model_inst.pulses(2);
      rdchk("stopped", `ETC_OFF_LIVE, 32'h0000_0000);
      rdchk("limit status", `ETC_OFF_STATUS, 32'h0000_0003);
      // begin select off waits for a software clear; clear on exposure begin
      apb(1'b1, `ETC_OFF_CTRL, 32'h0000_0000);
      apb(1'b1, `ETC_OFF_CTRL, ctrlVal(1'b1, SRC_OFF, SRC_EXP_BEGIN));
      etc_camera_model_inst.pulses(2);
      rdchk("off halts", `ETC_OFF_STATE, 32'h0000_0003);
      apb(1'b1, `ETC_OFF_CMD, 32'h0000_0001);
      etc_camera_model_inst.pulses(2);
      etc_camera_model_inst.pulse(0);
      rdchk("capt begin clear", `ETC_OFF_CAPT, 32'h0000_0002);
      rdchk("state off", `ETC_OFF_STATE, 32'h0000_0003);
      // begin and clear on the limit itself: the period restarts
      apb(1'b1, `ETC_OFF_CTRL, 32'h0000_0000);
      apb(1'b1, `ETC_OFF_CTRL, ctrlVal(1'b1, SRC_LIMIT, SRC_LIMIT));
      etc_camera_model_inst.pulses(2 * lim);
      @(posedge ref_clk);
      check("limit restart", 32'(limitHits - hits0), 32'h0000_0003);
      $display("test limit done");
      conclude();
   end
endmodule // elapsed_time_event_counter_test

// ### testbench/etc_camera_model.sv
// Purpose: camera event sources driving the counter's event and increment levels
// Assumes: levels change by non-blocking assignment just after a rising edge
// Notes: each pulse is one cycle high and one cycle low, so every call gives one clean rising edge
module etc_camera_model (
   input wire logic ref_clk,
   output logic beginEvt,
   output logic finishEvt,
   output logic extInc
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle low from time zero, lines are never left floating
   initial begin
      beginEvt = 1'b0;
      finishEvt = 1'b0;
      extInc = 1'b0;
   end

   // 0 exposure begin, 1 exposure finish, else one external increment
   task automatic pulse(input int which);
      @(posedge ref_clk);
      case (which)
         0: beginEvt <= 1'b1;
         1: finishEvt <= 1'b1;
         default: extInc <= 1'b1;
      endcase
      @(posedge ref_clk);
      beginEvt <= 1'b0;
      finishEvt <= 1'b0;
      extInc <= 1'b0;
      @(posedge ref_clk);
   endtask

   // arbitrary levels on all three lines from the next edge, to shake the edge detectors
   task automatic levels(input logic [2:0] v);
      @(posedge ref_clk);
      {beginEvt, finishEvt, extInc} <= v;
   endtask

   // a burst of increments, spaced so none merge
   task automatic pulses(input int count);
      repeat (count) pulse(2);
   endtask
endmodule // etc_camera_model
